// ---- test/fsr_host_model.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Host side of the command port
// ----------------------------------------------------------------------
module fsr_host_model (
  input  wire logic         clock_i,
  input  wire logic         busy_i,
  input  wire logic         error_i,
  input  wire logic         rvalid_i,
  input  wire logic [255:0] rdata_i,
  output logic              valid_o,
  output logic              write_o,
  output logic      [7:0]   code_o,
  output logic      [7:0]   wdata_o
);
  // Idle at time zero
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    code_o  = 8'h00;
    wdata_o = 8'h00;
  end

  // One command, driven at the falling edge, held over one taking edge
  task automatic issue(input logic w, input logic [7:0] c, input logic [7:0] d,
                       output logic err, output logic [255:0] rd,
                       output logic ok);
    int n;
    logic bz;
    logic hung;
    err = 1'b0;
    ok  = 1'b0;
    rd  = '0;
    bz  = 1'b0;
    @(negedge clock_i);
    // Wait up to eight cycles for a read in flight to end, then offer the command anyway
    for (n = 0; n < 8 && busy_i !== 1'b0; n++) begin
      @(negedge clock_i);
    end
    // Busy past the bound counts against the caller's checks
    hung = (busy_i !== 1'b0);
    valid_o = 1'b1;
    write_o = w;
    code_o  = c;
    wdata_o = d;
    @(negedge clock_i);
    // Released lines must not keep their last value
    valid_o = 1'b0;
    write_o = ~write_o;
    code_o  = ~code_o;
    wdata_o = ~wdata_o;
    // Answers stand one cycle, so look at every cycle
    for (n = 0; n < 4; n++) begin
      // A taken read shows busy in the cycle after the taking edge
      if (n == 0) begin
        bz = busy_i;
      end
      if (error_i === 1'b1) begin
        err = 1'b1;
      end
      if (rvalid_i === 1'b1) begin
        ok = (bz === 1'b1);
        rd = rdata_i;
      end
      @(negedge clock_i);
    end
    if (hung) begin
      err = 1'bx;
      ok  = 1'b0;
    end
  endtask
endmodule

// ---- test/fsr_recorder_tb.sv ----
`timescale 1ns/100ps
`include "fsr_map.svh"

module fsr_recorder_tb
  import fsr_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam logic [255:0] MASK = ~(256'hFFFF << 144); // Uptime aside
  logic         clock_i, reset_n_i, running, vin_lost, sensor_sel, smp;
  logic [7:0]   st [5];       // cml, temp, vin, iout, vout
  logic [7:0]   st_byte;
  logic [15:0]  st_word;
  logic [15:0]  m [6];        // temp_int, temp_ext, iout, vout, vin, duty
  logic [15:0]  old [4];      // iout, vout, vin, duty at normal sample
  logic         c_valid, c_write, busy, err, rvalid, done;
  logic [7:0]   c_code, c_wdata;
  logic [255:0] rdata;
  logic [4:0]   count;
  logic [255:0] recs [$];     // Newest first
  int           error_cnt, tests_run, cnt, cyc, i;

  always #20 clock_i = ~clock_i;

  // Cycles since reset release, for the uptime estimate
  always @(posedge clock_i) cyc <= reset_n_i ? cyc + 1 : 0;

  fsr_host_model host (.clock_i(clock_i), .busy_i(busy), .error_i(err),
    .rvalid_i(rvalid), .rdata_i(rdata), .valid_o(c_valid),
    .write_o(c_write), .code_o(c_code), .wdata_o(c_wdata));

  fsr_recorder #(.CYCLES_PER_SEC(10), .RECORDS(20)) dut (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .cmd_valid_i(c_valid),
    .cmd_write_i(c_write), .cmd_code_i(c_code), .cmd_wdata_i(c_wdata),
    .cmd_busy_o(busy), .cmd_error_o(err), .rvalid_o(rvalid),
    .rdata_o(rdata), .converter_running_i(running), .vin_lost_i(vin_lost),
    .sensor_sel_i(sensor_sel), .status_cml_i(st[0]), .status_temp_i(st[1]),
    .status_vin_i(st[2]), .status_iout_i(st[3]), .status_vout_i(st[4]),
    .status_byte_i(st_byte), .status_word_i(st_word), .temp_int_i(m[0]),
    .temp_ext_i(m[1]), .iout_i(m[2]), .vout_i(m[3]), .vin_i(m[4]),
    .duty_i(m[5]), .sample_normal_i(smp), .snapshot_done_o(done),
    .record_count_o(count));

  // ----------------------------------------------------------------------
  // Expectations and checks
  // ----------------------------------------------------------------------
  function automatic logic [255:0] exp_rec(input logic [7:0] sh,
                                           input logic [15:0] up);
    return {24'h000000, sh, st[0], st[1], st[2], st[3], st[4], st_byte,
            st_word, up, sensor_sel ? m[0] : m[1], sensor_sel ? m[1] : m[0],
            m[2], m[3], m[4], old[3], old[0], old[1], old[2]};
  endfunction

  // Uptime is only known to within a second of the bench's estimate
  function automatic logic match(input logic [255:0] g, input logic [255:0] x);
    logic [15:0] d;
    d = g[159:144] - x[159:144];
    return ((g & MASK) === (x & MASK)) && (d + 16'h0001 <= 16'h0002);
  endfunction

  task automatic check(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("unexpected at %0t: %s", $time, msg);
    end
  endtask

  task automatic cmd(input logic w, input logic [7:0] c, input logic [7:0] d,
                     input logic x);
    logic e, ok;
    logic [255:0] rd;
    host.issue(w, c, d, e, rd, ok);
    check(e === x, "command refusal");
  endtask

  task automatic idx_is(input logic [7:0] v);
    logic e, ok;
    logic [255:0] rd;
    host.issue(1'b0, `FSR_CMD_INDEX, 8'h00, e, rd, ok);
    check(ok && (rd === {248'h0, v}), "index readback");
  endtask

  task automatic read_rec(input logic [7:0] idx);
    logic e, ok;
    logic [255:0] rd;
    host.issue(1'b1, `FSR_CMD_INDEX, idx, e, rd, ok);
    check(e === 1'b0, "index select");
    host.issue(1'b0, `FSR_CMD_READOUT, 8'h00, e, rd, ok);
    check(ok && match(rd, idx < recs.size() ? recs[idx] : '0),
          "readout");
  endtask

  // Normal sample, fresh live values, then an input loss event
  task automatic snap(input logic run, input logic stat_on);
    int k, pulses;
    logic take;
    @(negedge clock_i);
    for (k = 0; k < 6; k++) m[k] = 16'($urandom);
    smp = 1'b1;
    @(negedge clock_i);
    smp = 1'b0;
    for (k = 0; k < 4; k++) old[k] = m[k + 2];
    for (k = 0; k < 6; k++) m[k] = 16'($urandom);
    // Only one gating status byte in st nonzero: the narrowest case that must record
    for (k = 0; k < 5; k++) st[k] = 8'h00;
    if (stat_on) st[$urandom_range(4, 0)] = 8'($urandom_range(255, 1));
    st_byte = 8'($urandom_range(255, 1));
    st_word = 16'($urandom_range(65535, 1));
    sensor_sel = 1'($urandom);
    running = run;
    @(negedge clock_i);
    vin_lost = 1'b1;
    take = run && stat_on;
    if (take) begin
      if (cnt < 255) cnt++;
      recs.push_front(exp_rec(8'(cnt), 16'((cyc - 2) / 10)));
      if (recs.size() > 20) void'(recs.pop_back());
    end
    pulses = 0;
    // Level held high must not record again
    for (k = 0; k < 3; k++) begin
      @(negedge clock_i);
      if (done === 1'b1) pulses++;
    end
    check(pulses == int'(take), "snapshot pulse");
    vin_lost = 1'b0;
    check(count === 5'(recs.size()), "record count");
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    clock_i = 1'b0;
    reset_n_i = 1'b0;
    {running, vin_lost, sensor_sel, smp, st_byte, st_word} = '0;
    for (i = 0; i < 5; i++) st[i] = 8'h00;
    for (i = 0; i < 6; i++) m[i] = 16'h0000;
    error_cnt = 0;
    tests_run = 0;
    cnt = 0;
    i = $urandom(32'h7E37A74A);
    repeat (4) @(negedge clock_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clock_i);
    idx_is(8'h00);
    read_rec(8'h00);
    cmd(1'b1, `FSR_CMD_INDEX, `FSR_INDEX_MAX, 1'b0);
    cmd(1'b1, `FSR_CMD_INDEX, 8'h14, 1'b1);
    idx_is(`FSR_INDEX_MAX);
    cmd(1'b1, `FSR_CMD_STORE_ALL, 8'h00, 1'b0);
    cmd(1'b0, `FSR_CMD_STORE_ALL, 8'h00, 1'b1);
    cmd(1'b1, `FSR_CMD_READOUT, 8'h00, 1'b1);
    cmd(1'b0, 8'h5A, 8'h00, 1'b1);
    snap(1'b1, 1'b1);
    read_rec(8'h00);
    snap(1'b0, 1'b1);
    snap(1'b1, 1'b0);
    for (i = 0; i < 21; i++) snap(1'b1, 1'b1);
    read_rec(8'h00);
    read_rec(`FSR_INDEX_MAX);
    for (i = 0; i < 4; i++) read_rec(8'($urandom_range(19, 1)));
    // Index written and stored, then a power cycle in mid-run
    cmd(1'b1, `FSR_CMD_INDEX, 8'h07, 1'b0);
    cmd(1'b1, `FSR_CMD_STORE_ALL, 8'h00, 1'b0);
    @(negedge clock_i);
    reset_n_i = 1'b0;
    repeat (2) @(negedge clock_i);
    reset_n_i = 1'b1;
    recs.delete();
    cnt = 0;
    repeat (3) @(negedge clock_i);
    check(count === 5'h00, "count after reset");
    idx_is(8'h00);
    snap(1'b1, 1'b1);
    read_rec(8'h00);
    stop_test();
  end
endmodule

// ---- verilog/fsr_map.svh ----
`ifndef FSR_MAP_SVH
`define FSR_MAP_SVH

// ----------------------------------------------------------------------
// Command codes on the management bus
// ----------------------------------------------------------------------
`define FSR_CMD_STORE_ALL   8'h15
`define FSR_CMD_INDEX       8'hD5
`define FSR_CMD_READOUT     8'hD7

// ----------------------------------------------------------------------
// Index register
// ----------------------------------------------------------------------
`define FSR_INDEX_RESET     8'h00
`define FSR_INDEX_MAX       8'h13
`define FSR_RECORDS         20

// ----------------------------------------------------------------------
// Record field positions (low bit of each field)
// ----------------------------------------------------------------------
`define FSR_F_SHUTDOWNS     224
`define FSR_F_STAT_CML      216
`define FSR_F_STAT_TEMP     208
`define FSR_F_STAT_VIN      200
`define FSR_F_STAT_IOUT     192
`define FSR_F_STAT_VOUT     184
`define FSR_F_STAT_BYTE     176
`define FSR_F_STAT_WORD     160
`define FSR_F_UPTIME        144
`define FSR_F_TEMP_OTHER    128
`define FSR_F_TEMP_CHOSEN   112
`define FSR_F_IOUT_SNAP     96
`define FSR_F_VOUT_SNAP     80
`define FSR_F_VIN_SNAP      64
`define FSR_F_DUTY_OLD      48
`define FSR_F_IOUT_OLD      32
`define FSR_F_VOUT_OLD      16
`define FSR_F_VIN_OLD       0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define FSR_CLK_PERIOD_NS   40
`define FSR_SECOND_NS       1000000000
`define FSR_CYCLES_PER_SEC  (`FSR_SECOND_NS / `FSR_CLK_PERIOD_NS)

`endif

// ---- verilog/fsr_pkg.sv ----
package fsr_pkg;

  // ----------------------------------------------------------------------
  // Command sequencer states, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    FSR_ST_IDLE = 2'b01,  // Waiting for a command
    FSR_ST_WAIT = 2'b10   // Record read from the store in flight
  } fsr_state_t;

  // Kind of answer being prepared
  typedef enum logic [1:0] {
    FSR_ANS_INDEX  = 2'b01,
    FSR_ANS_RECORD = 2'b10
  } fsr_answer_t;

endpackage

// ---- verilog/fsr_record_mem.sv ----
`timescale 1ns/100ps

// ----------------------------------------------------------------------
// Snapshot record store: one write port, one registered read port
// ----------------------------------------------------------------------
module fsr_record_mem
  import fsr_pkg::*;
#(
  parameter int WIDTH = 256,
  parameter int DEPTH = 20,
  parameter int AW    = 5
) (
  input  wire logic             clock_i,
  input  wire logic             wr_en_i,
  input  wire logic [AW-1:0]    wr_addr_i,
  input  wire logic [WIDTH-1:0] wr_data_i,
  input  wire logic             rd_en_i,
  input  wire logic [AW-1:0]    rd_addr_i,
  output logic      [WIDTH-1:0] rd_data_o
);

  // Contents are not reset: they stand for the nonvolatile store
  logic [WIDTH-1:0] cells [DEPTH];

  // Write port
  always_ff @(posedge clock_i) begin
    if (wr_en_i) begin
      cells[wr_addr_i] <= wr_data_i;
    end
  end

  // Registered read, old data when read and write meet
  always_ff @(posedge clock_i) begin
    if (rd_en_i) begin
      rd_data_o <= cells[rd_addr_i];
    end
  end

endmodule

// ---- verilog/fsr_recorder.sv ----
`timescale 1ns/100ps
`include "fsr_map.svh"


module fsr_recorder
  import fsr_pkg::*;
#(
  parameter int CYCLES_PER_SEC = `FSR_CYCLES_PER_SEC,
  parameter int RECORDS        = `FSR_RECORDS
) (
  input  wire logic         clock_i,
  input  wire logic         reset_n_i,
  // Management command port
  input  wire logic         cmd_valid_i,
  input  wire logic         cmd_write_i,
  input  wire logic [7:0]   cmd_code_i,
  input  wire logic [7:0]   cmd_wdata_i,
  output logic              cmd_busy_o,
  output logic              cmd_error_o,
  output logic              rvalid_o,
  output logic      [255:0] rdata_o,
  // Converter state
  input  wire logic         converter_running_i,
  input  wire logic         vin_lost_i,
  input  wire logic         sensor_sel_i,
  // Status bytes
  input  wire logic [7:0]   status_cml_i,
  input  wire logic [7:0]   status_temp_i,
  input  wire logic [7:0]   status_vin_i,
  input  wire logic [7:0]   status_iout_i,
  input  wire logic [7:0]   status_vout_i,
  input  wire logic [7:0]   status_byte_i,
  input  wire logic [15:0]  status_word_i,
  // Live measurements
  input  wire logic [15:0]  temp_int_i,
  input  wire logic [15:0]  temp_ext_i,
  input  wire logic [15:0]  iout_i,
  input  wire logic [15:0]  vout_i,
  input  wire logic [15:0]  vin_i,
  input  wire logic [15:0]  duty_i,
  input  wire logic         sample_normal_i,
  // Record activity
  output logic              snapshot_done_o,
  output logic      [4:0]   record_count_o
);

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;  // First stage, read only by the second
  logic rst_n_q;   // Released copy used everywhere

  // Assert at once, release after two edges
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n_q  <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------------
  fsr_state_t  state;       // Sequencer state
  fsr_state_t  next_state;  // Its next value
  fsr_answer_t answer;      // What the pending read returns
  logic [7:0]  index;       // Snapshot history index, volatile
  logic [4:0]  wr_ptr;      // Slot for the next record
  logic [4:0]  count;       // Records kept, up to twenty
  logic        rd_empty;    // Selected slot holds no record
  logic [7:0]  shutdowns;   // Shutdowns seen in operation

  wire idle     = (state == FSR_ST_IDLE);
  wire take     = cmd_valid_i && idle;
  wire hit_idx  = (cmd_code_i == `FSR_CMD_INDEX);
  wire hit_rec  = (cmd_code_i == `FSR_CMD_READOUT);
  wire hit_sto  = (cmd_code_i == `FSR_CMD_STORE_ALL);
  wire idx_ok   = (cmd_wdata_i <= `FSR_INDEX_MAX);
  wire wr_index = take && cmd_write_i && hit_idx && idx_ok;
  wire rd_any   = take && !cmd_write_i && (hit_idx || hit_rec);
  wire bad_cmd  = take && !rd_any && !wr_index
                  && !(cmd_write_i && hit_sto);

  // ----------------------------------------------------------------------
  // Index register
  // ----------------------------------------------------------------------
  // Store-all is accepted but leaves the index out of what is saved
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      index <= `FSR_INDEX_RESET;
    end else if (wr_index) begin
      // Values past the last record are refused, not wrapped
      index <= cmd_wdata_i;
    end
  end

  // ----------------------------------------------------------------------
  // Snapshot trigger
  // ----------------------------------------------------------------------
  logic vin_lost_q;  // Last value of the loss level

  // Edge history of the loss level
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      vin_lost_q <= 1'b0;
    end else begin
      vin_lost_q <= vin_lost_i;
    end
  end

  wire any_status = |{status_vout_i, status_iout_i, status_vin_i,
                      status_temp_i, status_cml_i};
  wire snap_we    = vin_lost_i && !vin_lost_q
                    && converter_running_i && any_status;

  // ----------------------------------------------------------------------
  // Normal-operation samples
  // ----------------------------------------------------------------------
  logic [15:0] duty_old;  // Duty cycle, linear percent
  logic [15:0] iout_old;  // Load current, linear amperes
  logic [15:0] vout_old;  // Output voltage, output mode
  logic [15:0] vin_old;   // Input voltage, linear

  // Caught on each strobe so the record sees pre-fault values
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      duty_old <= 16'h0000;
      iout_old <= 16'h0000;
      vout_old <= 16'h0000;
      vin_old  <= 16'h0000;
    end else if (sample_normal_i) begin
      duty_old <= duty_i;
      iout_old <= iout_i;
      vout_old <= vout_i;
      vin_old  <= vin_i;
    end
  end

  // ----------------------------------------------------------------------
  // Record assembly
  // ----------------------------------------------------------------------
  logic [15:0] uptime;  // Seconds of this power cycle

  fsr_uptime #(
    .CYCLES_PER_SEC (CYCLES_PER_SEC)
  ) u_uptime (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_q),
    .seconds_o (uptime)
  );

  // Count includes the shutdown being recorded
  wire [7:0]  shut_next = (shutdowns == 8'hFF) ? 8'hFF
                          : shutdowns + 8'h01;
  wire [15:0] temp_sel  = sensor_sel_i ? temp_ext_i : temp_int_i;
  wire [15:0] temp_oth  = sensor_sel_i ? temp_int_i : temp_ext_i;

  // Counter field is 32 bits wide, the count itself only a byte
  wire [255:0] snap_data = {
    24'h000000, shut_next,
    status_cml_i, status_temp_i, status_vin_i,
    status_iout_i, status_vout_i, status_byte_i,
    status_word_i,
    uptime,
    temp_oth, temp_sel,
    iout_i, vout_i, vin_i,
    duty_old,
    iout_old,
    vout_old, vin_old
  };

  // ----------------------------------------------------------------------
  // Ring of records
  // ----------------------------------------------------------------------
  wire [4:0] last_slot = 5'(RECORDS - 1);

  // Newest at wr_ptr-1, oldest overwritten once the ring is full
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_ptr    <= 5'h00;
      count     <= 5'h00;
      shutdowns <= 8'h00;
    end else if (snap_we) begin
      wr_ptr    <= (wr_ptr == last_slot) ? 5'h00
                   : wr_ptr + 5'h01;
      count     <= (count == 5'(RECORDS)) ? count
                   : count + 5'h01;
      shutdowns <= shut_next;
    end
  end

  // Slot of the selected record, index zero is the newest
  wire [5:0] back  = 6'(wr_ptr) + 6'(RECORDS) - 6'h01
                     - 6'(index[4:0]);
  wire [4:0] slot  = (back >= 6'(RECORDS)) ? 5'(back - 6'(RECORDS))
                     : back[4:0];
  wire       empty = ({3'h0, count} <= index);

  logic [255:0] mem_rdata;  // Registered store output

  fsr_record_mem #(
    .WIDTH (256),
    .DEPTH (RECORDS),
    .AW    (5)
  ) u_mem (
    .clock_i   (clock_i),
    .wr_en_i   (snap_we),
    .wr_addr_i (wr_ptr),
    .wr_data_i (snap_data),
    .rd_en_i   (rd_any),
    .rd_addr_i (slot),
    .rd_data_o (mem_rdata)
  );

  // ----------------------------------------------------------------------
  // Read sequencer
  // ----------------------------------------------------------------------
  // Both reads take two cycles so the host sees one timing
  always_comb begin
    next_state = state;
    case (state)
      FSR_ST_IDLE: begin
        if (rd_any) begin
          next_state = FSR_ST_WAIT;
        end
      end
      FSR_ST_WAIT: begin
        next_state = FSR_ST_IDLE;
      end
      default: begin
        next_state = FSR_ST_IDLE;
      end
    endcase
  end

  // State and request capture
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      state    <= FSR_ST_IDLE;
      answer   <= FSR_ANS_INDEX;
      rd_empty <= 1'b0;
    end else begin
      state <= next_state;
      if (rd_any) begin
        answer   <= hit_rec ? FSR_ANS_RECORD : FSR_ANS_INDEX;
        rd_empty <= empty;
      end
    end
  end

  // Answer data, unwritten slots read as zero
  wire [255:0] ans_data =
    (answer == FSR_ANS_INDEX) ? {248'h0, index}
    : rd_empty               ? 256'h0
    : mem_rdata;

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  wire fin = (state == FSR_ST_WAIT);

  // All outputs are registered
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rvalid_o        <= 1'b0;
      rdata_o         <= 256'h0;
      cmd_error_o     <= 1'b0;
      cmd_busy_o      <= 1'b0;
      snapshot_done_o <= 1'b0;
      record_count_o  <= 5'h00;
    end else begin
      rvalid_o        <= fin;
      cmd_error_o     <= bad_cmd;
      cmd_busy_o      <= (next_state == FSR_ST_WAIT);
      snapshot_done_o <= snap_we;
      record_count_o  <= (snap_we && count != 5'(RECORDS))
                         ? count + 5'h01 : count;
      if (fin) begin
        rdata_o <= ans_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_q);

  a_index_store_all: assert property (
    (take && cmd_write_i && hit_sto) |=> $stable(index))
    else $error("Store-all changed the index");
  a_index_powerup: assert property (
    $rose(rst_n_q) |-> (index == 8'h00))
    else $error("Index not zero after reset");
  a_index_range: assert property (
    index <= `FSR_INDEX_MAX)
    else $error("Index past last record");
  a_readout_block: assert property (
    (rd_any && hit_rec) |-> ##2 rvalid_o)
    else $error("Readout answer late");
  a_snap_write: assert property (
    snap_we |=> snapshot_done_o && (wr_ptr != $past(wr_ptr)))
    else $error("Loss while running made no record");
  a_snap_gate: assert property (
    snapshot_done_o |-> $past(any_status))
    else $error("Record taken with all status clear");
  a_shutdown_byte: assert property (
    snap_we |-> (snap_data[255:224] == shut_next)
                && (snap_data[223:216] == status_cml_i))
    else $error("Shutdown count or status misplaced");
  a_uptime_field: assert property (
    snap_we |-> snap_data[159:144] == uptime)
    else $error("Power cycle length misplaced");
  a_temp_order: assert property (
    snap_we && sensor_sel_i |-> snap_data[127:112] == temp_ext_i)
    else $error("Chosen sensor not in low field");
  // Strobe two cycles back, none since: the held sample is known
  a_duty_old: assert property (
    $past(sample_normal_i, 2) && !$past(sample_normal_i) && snap_we
      |-> snap_data[63:48] == $past(duty_i, 2))
    else $error("Normal duty cycle misplaced");
  a_iout_old: assert property (
    $past(sample_normal_i, 2) && !$past(sample_normal_i) && snap_we
      |-> snap_data[47:32] == $past(iout_i, 2))
    else $error("Normal load current misplaced");
  a_volt_old: assert property (
    $past(sample_normal_i, 2) && !$past(sample_normal_i) && snap_we
      |-> snap_data[31:0] == $past({vout_i, vin_i}, 2))
    else $error("Normal voltages misplaced");
  a_snap_live: assert property (
    snap_we |-> snap_data[111:64] == {iout_i, vout_i, vin_i})
    else $error("Snapshot measurements misplaced");
  a_ring_full: assert property (
    (snap_we && count == 5'(RECORDS)) |=> count == 5'(RECORDS))
    else $error("Ring count left twenty");

  c_snapshot: cover property (snap_we);
  c_ring_wrap: cover property (snap_we && wr_ptr == last_slot);
  c_read_record: cover property (rvalid_o && answer == FSR_ANS_RECORD);
  c_bad_cmd: cover property (bad_cmd);

endmodule

// ---- verilog/fsr_uptime.sv ----
`timescale 1ns/100ps
`include "fsr_map.svh"

// ----------------------------------------------------------------------
// Whole seconds since reset release, saturating
// ----------------------------------------------------------------------
module fsr_uptime
  import fsr_pkg::*;
#(
  parameter int CYCLES_PER_SEC = `FSR_CYCLES_PER_SEC
) (
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  output logic      [15:0] seconds_o
);

  // Divider counter, one tick each second
  logic [31:0] div_cnt;
  wire         tick = (div_cnt == 32'(CYCLES_PER_SEC - 1));

  // Prescaler
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_cnt <= 32'h0000_0000;
    end else if (tick) begin
      div_cnt <= 32'h0000_0000;
    end else begin
      div_cnt <= div_cnt + 32'h0000_0001;
    end
  end

  // Saturate so a long run never wraps to a short one
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      seconds_o <= 16'h0000;
    end else if (tick && seconds_o != 16'hFFFF) begin
      seconds_o <= seconds_o + 16'h0001;
    end
  end

endmodule
